// ==== pkg/caf_pkg.sv ====
/*
  Package for the CAN receive acceptance filter: register offsets, field
  positions, reset values and encodings shared by the design and the bench.
  Assumes a 32-bit AHB-Lite register bus, one aligned word per register,
  with the 16-bit register contents in the low half of each word.
*/
`default_nettype none

package caf_pkg;

  // ==========================================================================
  // Sizes
  // ==========================================================================
  localparam int NUM_FILTERS = 16;
  localparam int NUM_MASKS   = 3;
  localparam int NUM_BUFPTR  = 4;
  localparam int NUM_MSKSEL  = 2;
  localparam int BP_PER_REG  = 4;
  localparam int MS_PER_REG  = 8;

  // ==========================================================================
  // Register byte offsets (low 12 address bits)
  // ==========================================================================
  localparam logic [11:0] OFS_FILT_EN  = 12'h000;
  localparam logic [11:0] OFS_BUFPTR   = 12'h004;
  localparam logic [11:0] OFS_MSKSEL   = 12'h014;
  localparam logic [11:0] OFS_RXFULL   = 12'h01c;
  localparam logic [11:0] OFS_RX_BUFFER_OVERFLOW_FLAG    = 12'h020;
  localparam logic [11:0] OFS_FILT_SID = 12'h040;
  localparam logic [11:0] OFS_FILT_EID = 12'h080;
  localparam logic [11:0] OFS_MASK_SID = 12'h0c0;
  localparam logic [11:0] OFS_MASK_EID = 12'h0d0;
  localparam logic [11:0] REG_STRIDE   = 12'h004;

  // ==========================================================================
  // Field layout of the standard identifier, buffer pointer and mask source registers
  // ==========================================================================
  localparam int SID_LSB     = 5;
  localparam int SID_MSB     = 15;
  localparam int TYPE_BIT    = 3;
  localparam int EIDHI_MSB   = 1;
  localparam int BP_WIDTH    = 4;
  localparam int MS_WIDTH    = 2;
  localparam logic [15:0] SID_REG_WMASK = 16'hffeb;

  // ==========================================================================
  // Encodings and reset values
  // ==========================================================================
  localparam logic [3:0]  BP_FIFO       = 4'hf;
  localparam logic [1:0]  MSK_NONE      = 2'h3;
  localparam logic [15:0] RST_FILT_EN   = 16'hffff;
  localparam logic [15:0] RST_ZERO      = 16'h0000;
  localparam logic [15:0] BUF_FLAG_MASK = 16'h7fff;

endpackage

`default_nettype wire

// ==== rtl/caf_acceptance_filter.sv ====
/*
  CAN receive acceptance filter: sixteen filters, three masks, buffer
  pointers, receive buffer full and overflow flags, behind an AHB-Lite slave.
  Assumes the protocol engine presents each received identifier for one
  cycle on rx_frame_valid, synchronous to hclk, and a single AHB master.
*/
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Pointer value 1111 routes the accepted frame to the receive FIFO.
// - Pointer values 0 to 14 route the frame to that receive buffer.
// - Four 4-bit pointers per register, highest filter in top nibble.
// - Unmasked standard identifier bits must equal filter bits 15-5.
// - Extended bits 17-16 from filter low bits, 15-0 from second register.
// - Type-match set: extended-select picks extended or standard frames only.
// - Type-match cleared: extended-select bit is ignored.
// - Mask source 00, 01, 10 pick masks 0-2; 11 applies no mask.
// - Mask source fields split over two registers, highest filter at 15-14.
// - Set standard mask bit compares that position; cleared is don't-care.
// - Mask bits 1-0 include extended positions 17-16 when set.
// - Type-match set accepts only frames of the selected identifier format.
// - Type-match cleared accepts either format on identifier match.
// - Three independent masks, each with standard and extended registers.
// - Sixteen filters, each with standard and extended value registers.
// - Bits 4 and 2 of standard identifier registers ignore writes, read zero.
// - A filter takes part only while its enable bit is set.
// - Extended mask bits 15-0 include position when set, else don't-care.
// - Storing into a buffer sets its full flag; software writes zero to clear.
// - Accepting into a still-full buffer sets that buffer's overflow flag.
module caf_acceptance_filter (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        rx_frame_valid,
  input  wire logic        rx_frame_ide,
  input  wire logic [10:0] rx_frame_sid,
  input  wire logic [17:0] rx_frame_eid,
  output logic             acc_valid,
  output logic             acc_hit,
  output logic             acc_to_fifo,
  output logic [3:0]       acc_buffer,
  output logic [3:0]       acc_filter,
  output logic             acc_overflow
);

  // ==========================================================================
  // Register storage
  // ==========================================================================
  logic [15:0] filt_en_ff;
  logic [15:0] bufptr_ff   [caf_pkg::NUM_BUFPTR];
  logic [15:0] msksel_ff   [caf_pkg::NUM_MSKSEL];
  logic [15:0] filt_sid_ff [caf_pkg::NUM_FILTERS];
  logic [15:0] filt_eid_ff [caf_pkg::NUM_FILTERS];
  logic [15:0] mask_sid_ff [caf_pkg::NUM_MASKS];
  logic [15:0] mask_eid_ff [caf_pkg::NUM_MASKS];
  logic [15:0] rx_full_ff;
  logic [15:0] rx_ovf_ff;

  // ==========================================================================
  // AHB-Lite slave
  // ==========================================================================
  logic        ap_valid_ff;
  logic        ap_write_ff;
  logic [11:0] ap_addr_ff;
  logic        rd_wait_ff;
  logic [31:0] hrdata_ff;
  logic [15:0] rd_value;
  logic        ap_take;
  logic        wr_go;

  // Address phase taken only when the bus is ready
  assign ap_take   = hsel && htrans[1] && hready;
  assign wr_go     = ap_valid_ff && ap_write_ff;
  // Reads stall one cycle so the data comes from a flip-flop
  assign hreadyout = !rd_wait_ff;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;

  // Address phase capture; hsize ignored, every access is a word
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_valid_ff <= 1'b0;
      ap_write_ff <= 1'b0;
      ap_addr_ff  <= 12'h000;
    end
    else if (ap_take)
    begin
      ap_valid_ff <= 1'b1;
      ap_write_ff <= hwrite;
      ap_addr_ff  <= haddr[11:0];
    end
    else if (hready)
    begin
      ap_valid_ff <= 1'b0;
    end
  end

  // One wait state on reads; lets a write just before settle first
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_wait_ff <= 1'b0;
    end
    else
    begin
      rd_wait_ff <= ap_take && !hwrite;
    end
  end

  // Read data latched at the end of the wait state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_ff <= 32'h0000_0000;
    end
    else if (rd_wait_ff)
    begin
      hrdata_ff <= {16'h0000, rd_value};
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rd_value = 16'h0000;
    if (ap_addr_ff == caf_pkg::OFS_FILT_EN)
      rd_value = filt_en_ff;
    if (ap_addr_ff == caf_pkg::OFS_RXFULL)
      rd_value = rx_full_ff;
    if (ap_addr_ff == caf_pkg::OFS_RX_BUFFER_OVERFLOW_FLAG)
      rd_value = rx_ovf_ff;
    for (int i = 0; i < caf_pkg::NUM_BUFPTR; i++)
    begin
      if (ap_addr_ff == caf_pkg::OFS_BUFPTR + 12'(i * 4))
        rd_value = bufptr_ff[i];
    end
    for (int i = 0; i < caf_pkg::NUM_MSKSEL; i++)
    begin
      if (ap_addr_ff == caf_pkg::OFS_MSKSEL + 12'(i * 4))
        rd_value = msksel_ff[i];
    end
    for (int i = 0; i < caf_pkg::NUM_FILTERS; i++)
    begin
      if (ap_addr_ff == caf_pkg::OFS_FILT_SID + 12'(i * 4))
        rd_value = filt_sid_ff[i];
      if (ap_addr_ff == caf_pkg::OFS_FILT_EID + 12'(i * 4))
        rd_value = filt_eid_ff[i];
    end
    for (int i = 0; i < caf_pkg::NUM_MASKS; i++)
    begin
      if (ap_addr_ff == caf_pkg::OFS_MASK_SID + 12'(i * 4))
        rd_value = mask_sid_ff[i];
      if (ap_addr_ff == caf_pkg::OFS_MASK_EID + 12'(i * 4))
        rd_value = mask_eid_ff[i];
    end
  end

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  // Filter enables, out of reset every filter is on
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      filt_en_ff <= caf_pkg::RST_FILT_EN;
    end
    else if (wr_go && ap_addr_ff == caf_pkg::OFS_FILT_EN)
    begin
      filt_en_ff <= hwdata[15:0];
    end
  end

  // Buffer pointers and mask source selects
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < caf_pkg::NUM_BUFPTR; i++)
        bufptr_ff[i] <= caf_pkg::RST_ZERO;
      for (int i = 0; i < caf_pkg::NUM_MSKSEL; i++)
        msksel_ff[i] <= caf_pkg::RST_ZERO;
    end
    else if (wr_go)
    begin
      for (int i = 0; i < caf_pkg::NUM_BUFPTR; i++)
      begin
        if (ap_addr_ff == caf_pkg::OFS_BUFPTR + 12'(i * 4))
          bufptr_ff[i] <= hwdata[15:0];
      end
      for (int i = 0; i < caf_pkg::NUM_MSKSEL; i++)
      begin
        if (ap_addr_ff == caf_pkg::OFS_MSKSEL + 12'(i * 4))
          msksel_ff[i] <= hwdata[15:0];
      end
    end
  end

  // Identifier values and masks; unused bits 4 and 2 of the standard registers stay zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < caf_pkg::NUM_FILTERS; i++)
      begin
        filt_sid_ff[i] <= caf_pkg::RST_ZERO;
        filt_eid_ff[i] <= caf_pkg::RST_ZERO;
      end
      for (int i = 0; i < caf_pkg::NUM_MASKS; i++)
      begin
        mask_sid_ff[i] <= caf_pkg::RST_ZERO;
        mask_eid_ff[i] <= caf_pkg::RST_ZERO;
      end
    end
    else if (wr_go)
    begin
      for (int i = 0; i < caf_pkg::NUM_FILTERS; i++)
      begin
        if (ap_addr_ff == caf_pkg::OFS_FILT_SID + 12'(i * 4))
          filt_sid_ff[i] <= hwdata[15:0] & caf_pkg::SID_REG_WMASK;
        if (ap_addr_ff == caf_pkg::OFS_FILT_EID + 12'(i * 4))
          filt_eid_ff[i] <= hwdata[15:0];
      end
      for (int i = 0; i < caf_pkg::NUM_MASKS; i++)
      begin
        if (ap_addr_ff == caf_pkg::OFS_MASK_SID + 12'(i * 4))
          mask_sid_ff[i] <= hwdata[15:0] & caf_pkg::SID_REG_WMASK;
        if (ap_addr_ff == caf_pkg::OFS_MASK_EID + 12'(i * 4))
          mask_eid_ff[i] <= hwdata[15:0];
      end
    end
  end

  // ==========================================================================
  // Per-filter comparison
  // ==========================================================================
  logic [15:0] filt_hit;
  logic [3:0]  filt_bp [caf_pkg::NUM_FILTERS];

  for (genvar f = 0; f < caf_pkg::NUM_FILTERS; f++)
  begin : g_filt
    logic [1:0]  msk_src;
    logic [10:0] msk_sid;
    logic [17:0] msk_eid;
    logic        msk_type;
    logic [10:0] val_sid;
    logic [17:0] val_eid;
    logic        sid_ok;
    logic        eid_ok;
    logic        type_ok;

    assign filt_bp[f] = bufptr_ff[f / caf_pkg::BP_PER_REG]
                        [(f % caf_pkg::BP_PER_REG) * caf_pkg::BP_WIDTH +: caf_pkg::BP_WIDTH];
    assign msk_src    = msksel_ff[f / caf_pkg::MS_PER_REG]
                        [(f % caf_pkg::MS_PER_REG) * caf_pkg::MS_WIDTH +: caf_pkg::MS_WIDTH];

    // No mask means every bit and the frame type are compared
    always_comb
    begin
      msk_sid  = 11'h7ff;
      msk_eid  = 18'h3ffff;
      msk_type = 1'b1;
      if (msk_src != caf_pkg::MSK_NONE)
      begin
        msk_sid  = mask_sid_ff[msk_src][caf_pkg::SID_MSB:caf_pkg::SID_LSB];
        msk_eid  = {mask_sid_ff[msk_src][caf_pkg::EIDHI_MSB:0], mask_eid_ff[msk_src]};
        msk_type = mask_sid_ff[msk_src][caf_pkg::TYPE_BIT];
      end
    end

    assign val_sid = filt_sid_ff[f][caf_pkg::SID_MSB:caf_pkg::SID_LSB];
    assign val_eid = {filt_sid_ff[f][caf_pkg::EIDHI_MSB:0], filt_eid_ff[f]};

    // Cleared mask bits drop out of the compare
    assign sid_ok  = ((rx_frame_sid ^ val_sid) & msk_sid) == 11'h000;
    // Extended bits only exist in extended frames
    assign eid_ok  = !rx_frame_ide || (((rx_frame_eid ^ val_eid) & msk_eid) == 18'h00000);
    // Frame format checked when the mask asks for it or no mask is selected
    assign type_ok = !msk_type || (filt_sid_ff[f][caf_pkg::TYPE_BIT] == rx_frame_ide);

    assign filt_hit[f] = filt_en_ff[f] && sid_ok && eid_ok && type_ok;
  end

  // ==========================================================================
  // Winner selection and buffer flags
  // ==========================================================================
  logic       any_hit;
  logic [3:0] win_filter;
  logic [3:0] win_bp;
  logic       win_fifo;
  logic [15:0] set_full;
  logic [15:0] clr_full;
  logic [15:0] clr_ovf;

  assign any_hit = |filt_hit;

  // Scan downward so the lowest matching filter is the last to win
  always_comb
  begin
    win_filter = 4'h0;
    for (int i = caf_pkg::NUM_FILTERS - 1; i >= 0; i--)
    begin
      if (filt_hit[i])
        win_filter = 4'(i);
    end
  end

  assign win_bp   = filt_bp[win_filter];
  assign win_fifo = (win_bp == caf_pkg::BP_FIFO);

  // One-hot store target; the FIFO has no flag here
  always_comb
  begin
    set_full = 16'h0000;
    if (rx_frame_valid && any_hit && !win_fifo)
      set_full[win_bp] = 1'b1;
  end

  // Writing zero clears, writing one leaves the flag alone
  assign clr_full = (wr_go && ap_addr_ff == caf_pkg::OFS_RXFULL) ? ~hwdata[15:0] : 16'h0000;
  assign clr_ovf  = (wr_go && ap_addr_ff == caf_pkg::OFS_RX_BUFFER_OVERFLOW_FLAG) ? ~hwdata[15:0] : 16'h0000;

  // Set beats a same-cycle clear so no stored frame goes unflagged
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_full_ff <= caf_pkg::RST_ZERO;
    end
    else
    begin
      rx_full_ff <= ((rx_full_ff & ~clr_full) | set_full) & caf_pkg::BUF_FLAG_MASK;
    end
  end

  // Overflow judged on the flag before this cycle's clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_ovf_ff <= caf_pkg::RST_ZERO;
    end
    else
    begin
      rx_ovf_ff <= ((rx_ovf_ff & ~clr_ovf) | (set_full & rx_full_ff)) & caf_pkg::BUF_FLAG_MASK;
    end
  end

  // ==========================================================================
  // Acceptance result towards the buffer memory
  // ==========================================================================
  logic       acc_valid_ff;
  logic       acc_hit_ff;
  logic       acc_to_fifo_ff;
  logic [3:0] acc_buffer_ff;
  logic [3:0] acc_filter_ff;
  logic       acc_overflow_ff;

  // Result fields stand until the next frame replaces them; acc_valid is high for one cycle only
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      acc_valid_ff    <= 1'b0;
      acc_hit_ff      <= 1'b0;
      acc_to_fifo_ff  <= 1'b0;
      acc_buffer_ff   <= 4'h0;
      acc_filter_ff   <= 4'h0;
      acc_overflow_ff <= 1'b0;
    end
    else
    begin
      acc_valid_ff <= rx_frame_valid;
      if (rx_frame_valid)
      begin
        acc_hit_ff      <= any_hit;
        acc_to_fifo_ff  <= any_hit && win_fifo;
        acc_buffer_ff   <= win_bp;
        acc_filter_ff   <= win_filter;
        acc_overflow_ff <= |(set_full & rx_full_ff);
      end
    end
  end

  assign acc_valid    = acc_valid_ff;
  assign acc_hit      = acc_hit_ff;
  assign acc_to_fifo  = acc_to_fifo_ff;
  assign acc_buffer   = acc_buffer_ff;
  assign acc_filter   = acc_filter_ff;
  assign acc_overflow = acc_overflow_ff;

endmodule

`default_nettype wire

// ==== testbench/caf_checker_sva.sv ====
/*
  Port checker for the acceptance filter.
  Assumes a bind from the bench top; hready is tied to hreadyout.
*/
`timescale 1ns/1ps
`default_nettype none
module caf_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        rx_frame_valid,
  input wire logic        acc_valid,
  input wire logic        acc_hit,
  input wire logic        acc_to_fifo,
  input wire logic [3:0]  acc_buffer,
  input wire logic [3:0]  acc_filter,
  input wire logic        acc_overflow
);
  // ==========================================================================
  // Helpers
  // ==========================================================================
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_go;
  logic rd_sid;
  logic rd_flag;
  // Read taken this edge; sid regions cover filter and mask value words
  assign rd_go   = hsel && htrans[1] && !hwrite && hreadyout;
  assign rd_sid  = rd_go && (haddr[11:6] == 6'h01 || haddr[11:4] == 8'h0c);
  assign rd_flag = rd_go && (haddr[11:0] == caf_pkg::OFS_RXFULL || haddr[11:0] == caf_pkg::OFS_RX_BUFFER_OVERFLOW_FLAG);

  // ==========================================================================
  // Properties
  // ==========================================================================
  property p_valid_follow; rx_frame_valid |=> acc_valid; endproperty
  a_valid_follow: assert property (p_valid_follow) else $error("no verdict after frame");
  property p_valid_only; !rx_frame_valid |=> !acc_valid; endproperty
  a_valid_only: assert property (p_valid_only) else $error("verdict without frame");
  property p_fifo; acc_valid && acc_hit && acc_buffer == 4'hf |-> acc_to_fifo; endproperty
  a_fifo: assert property (p_fifo) else $error("pointer 1111 not sent to fifo");
  property p_buffer; acc_to_fifo |-> acc_hit && acc_buffer == 4'hf; endproperty
  a_buffer: assert property (p_buffer) else $error("fifo chosen for a buffer pointer");
  property p_ovf; acc_overflow |-> acc_hit && !acc_to_fifo; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow without buffer store");
  // Verdict fields stand between frames
  property p_hold;
    !rx_frame_valid |=> $stable({acc_hit, acc_to_fifo, acc_buffer, acc_filter, acc_overflow});
  endproperty
  a_hold: assert property (p_hold) else $error("verdict changed without frame");
  property p_sid_read; rd_sid |=> ##1 (hrdata[4] == 1'b0 && hrdata[2] == 1'b0); endproperty
  a_sid_read: assert property (p_sid_read) else $error("unused id bits read nonzero");
  property p_flag_read; rd_flag |=> ##1 hrdata[15] == 1'b0; endproperty
  a_flag_read: assert property (p_flag_read) else $error("flag for buffer 15 set");
  c_fifo: cover property (acc_valid && acc_to_fifo);
  c_ovf: cover property (acc_valid && acc_overflow);
  c_miss: cover property (acc_valid && !acc_hit);
endmodule
`default_nettype wire

// ==== testbench/caf_frame_src.sv ====
/*
  Frame source in place of the CAN protocol engine.
  Assumes send is called just after a rising edge of hclk.
*/
`timescale 1ns/1ps
`default_nettype none
module caf_frame_src (
  input  wire logic        hclk,
  output var  logic        rx_frame_valid,
  output var  logic        rx_frame_ide,
  output var  logic [10:0] rx_frame_sid,
  output var  logic [17:0] rx_frame_eid
);
  // Idle lines start at zero, then carry the inverse id after a send so a stale copy never matches
  initial
  begin
    rx_frame_valid = 1'b0;
    rx_frame_ide   = 1'b0;
    rx_frame_sid   = 11'h0;
    rx_frame_eid   = 18'h0;
  end
  task send(input logic i, input logic [10:0] s, input logic [17:0] e);
    rx_frame_valid <= 1'b1;
    rx_frame_ide   <= i;
    rx_frame_sid   <= s;
    rx_frame_eid   <= e;
    @(posedge hclk);
    rx_frame_valid <= 1'b0;
    rx_frame_ide   <= ~i;
    rx_frame_sid   <= ~s;
    rx_frame_eid   <= ~e;
  endtask
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
/*
  Self-checking bench for the acceptance filter: AHB-Lite master tasks,
  frame scenarios. Assumes the checker and frame source files.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rdat_n;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        rx_frame_valid, rx_frame_ide, rdy_n;
  logic [10:0] rx_frame_sid;
  logic [17:0] rx_frame_eid;
  logic        acc_valid, acc_hit, acc_to_fifo, acc_overflow;
  logic [3:0]  acc_buffer, acc_filter;
  int          fails, total_checks;

  // ==========================================================================
  // Clock, bus capture, instances
  // ==========================================================================
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // Bus outputs stand from edge to edge, so mid-cycle equals the edge value
  always @(negedge hclk)
  begin
    rdy_n  <= hreadyout;
    rdat_n <= hrdata;
  end
  assign hready = hreadyout;
  caf_frame_src i_src (.hclk(hclk), .rx_frame_valid(rx_frame_valid), .rx_frame_ide(rx_frame_ide),
    .rx_frame_sid(rx_frame_sid), .rx_frame_eid(rx_frame_eid));
  caf_acceptance_filter i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rx_frame_valid(rx_frame_valid),
    .rx_frame_ide(rx_frame_ide), .rx_frame_sid(rx_frame_sid), .rx_frame_eid(rx_frame_eid),
    .acc_valid(acc_valid), .acc_hit(acc_hit), .acc_to_fifo(acc_to_fifo),
    .acc_buffer(acc_buffer), .acc_filter(acc_filter), .acc_overflow(acc_overflow));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [15:0] d);
    haddr  <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (rdy_n !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    @(posedge hclk);
    while (rdy_n !== 1'b1) @(posedge hclk);
  endtask
  task wr(input logic [11:0] a, input logic [15:0] d);
    xfer(1'b1, a, d);
  endtask
  task rc(input logic [11:0] a, input logic [15:0] e, input string n);
    xfer(1'b0, a, 16'h0);
    chk(n, e, rdat_n[15:0]);
    chk("hresp", 16'h0, 16'(hresp));
  endtask
  // One frame and its verdict, looked at in the cycle it stands
  task fr(input logic i, input logic [10:0] s, input logic [17:0] e,
          input logic h, input logic [3:0] f, input logic [3:0] b, input logic o);
    i_src.send(i, s, e);
    @(negedge hclk);
    chk("acc_valid", 16'h1, 16'(acc_valid));
    chk("acc_hit", 16'(h), 16'(acc_hit));
    if (h)
    begin
      chk("acc_filter", 16'(f), 16'(acc_filter));
      chk("acc_buffer", 16'(b), 16'(acc_buffer));
      chk("acc_to_fifo", 16'(b == 4'hf), 16'(acc_to_fifo));
      chk("acc_overflow", 16'(o), 16'(acc_overflow));
    end
    @(posedge hclk);
  endtask
  task results;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task t_regs;
    rc(caf_pkg::OFS_FILT_EN, 16'hffff, "filt_en");
    rc(caf_pkg::OFS_BUFPTR + 12'h004, 16'h0, "bufptr");
    rc(caf_pkg::OFS_MSKSEL + 12'h004, 16'h0, "msksel");
    wr(caf_pkg::OFS_BUFPTR + 12'h004, 16'h1234);
    rc(caf_pkg::OFS_BUFPTR + 12'h004, 16'h1234, "bufptr");
    wr(caf_pkg::OFS_FILT_SID + 12'h03c, 16'hffff);
    rc(caf_pkg::OFS_FILT_SID + 12'h03c, 16'hffeb, "filt_sid");
    wr(caf_pkg::OFS_MASK_SID + 12'h008, 16'hffff);
    rc(caf_pkg::OFS_MASK_SID + 12'h008, 16'hffeb, "mask_sid");
    wr(caf_pkg::OFS_MASK_SID + 12'h008, 16'h0);
    wr(12'h100, 16'h5555);
    rc(12'h100, 16'h0, "unmapped");
    $display("test regs done");
  endtask
  task t_flags;
    fr(1'b0, 11'h555, 18'h0, 1'b1, 4'h0, 4'h0, 1'b0);
    rc(caf_pkg::OFS_RXFULL, 16'h0001, "full");
    fr(1'b1, 11'h2aa, 18'h3ffff, 1'b1, 4'h0, 4'h0, 1'b1);
    rc(caf_pkg::OFS_RX_BUFFER_OVERFLOW_FLAG, 16'h0001, "ovf");
    wr(caf_pkg::OFS_RXFULL, 16'h0);
    rc(caf_pkg::OFS_RXFULL, 16'h0, "full");
    wr(caf_pkg::OFS_RX_BUFFER_OVERFLOW_FLAG, 16'h0);
    rc(caf_pkg::OFS_RX_BUFFER_OVERFLOW_FLAG, 16'h0, "ovf");
    $display("test flags done");
  endtask
  // Mid-run reset brings the filter enables, one pointer register and the full flags back to reset values
  task t_reset;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rc(caf_pkg::OFS_FILT_EN, 16'hffff, "filt_en");
    rc(caf_pkg::OFS_BUFPTR + 12'h004, 16'h0, "bufptr");
    rc(caf_pkg::OFS_RXFULL, 16'h0, "full");
    $display("test reset done");
  endtask
  task t_match;
    wr(caf_pkg::OFS_FILT_EN, 16'h0220);
    wr(caf_pkg::OFS_BUFPTR + 12'h004, 16'h00f0);
    wr(caf_pkg::OFS_BUFPTR + 12'h008, 16'h00e0);
    wr(caf_pkg::OFS_MSKSEL, 16'h0400);
    wr(caf_pkg::OFS_MSKSEL + 12'h004, 16'h000c);
    wr(caf_pkg::OFS_MASK_SID + 12'h004, 16'hffe8);
    wr(caf_pkg::OFS_FILT_SID + 12'h014, 16'h2460);
    wr(caf_pkg::OFS_FILT_SID + 12'h024, 16'h246a);
    wr(caf_pkg::OFS_FILT_EID + 12'h024, 16'habcd);
    fr(1'b0, 11'h123, 18'h0, 1'b1, 4'h5, 4'hf, 1'b0);
    fr(1'b0, 11'h122, 18'h0, 1'b0, 4'h0, 4'h0, 1'b0);
    fr(1'b1, 11'h123, 18'h2abcd, 1'b1, 4'h9, 4'he, 1'b0);
    fr(1'b1, 11'h123, 18'h2abcc, 1'b0, 4'h0, 4'h0, 1'b0);
    fr(1'b1, 11'h123, 18'h1abcd, 1'b0, 4'h0, 4'h0, 1'b0);
    rc(caf_pkg::OFS_RXFULL, 16'h4000, "full");
    wr(caf_pkg::OFS_MASK_SID + 12'h004, 16'hffc0);
    fr(1'b1, 11'h123, 18'h2abcd, 1'b1, 4'h5, 4'hf, 1'b0);
    fr(1'b0, 11'h122, 18'h0, 1'b1, 4'h5, 4'hf, 1'b0);
    wr(caf_pkg::OFS_MASK_EID + 12'h004, 16'hffff);
    fr(1'b1, 11'h123, 18'h00001, 1'b0, 4'h0, 4'h0, 1'b0);
    wr(caf_pkg::OFS_MASK_SID + 12'h004, 16'hffc1);
    fr(1'b1, 11'h123, 18'h10000, 1'b0, 4'h0, 4'h0, 1'b0);
    $display("test match done");
  endtask
  // Masks 0 and 2 are all don't-care, mask 1 and no-mask are not
  task t_masks;
    for (int ms = 0; ms < 4; ms++)
    begin
      wr(caf_pkg::OFS_MSKSEL, 16'(ms) << 10);
      fr(1'b0, 11'h7ff, 18'h0, ms == 0 || ms == 2, 4'h5, 4'hf, 1'b0);
    end
    $display("test masks done");
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  // ==========================================================================
  initial
  begin
    fails = 0;
    total_checks = 0;
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_flags();
    t_match();
    t_masks();
    t_reset();
    results();
  end
  // Run takes about 150 cycles
  initial
  begin
    repeat (20000) @(posedge hclk);
    fails++;
    results();
  end
endmodule

bind caf_acceptance_filter caf_checker i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout), .hrdata(hrdata),
  .rx_frame_valid(rx_frame_valid), .acc_valid(acc_valid), .acc_hit(acc_hit),
  .acc_to_fifo(acc_to_fifo), .acc_buffer(acc_buffer), .acc_filter(acc_filter),
  .acc_overflow(acc_overflow));
`default_nettype wire
